// ---- design/wave_channel.v ----
// One compare-output channel: connection decode and output state.
// Assumes events arrive as one-cycle pulses from the timer core.
`include "wave_defines.vh"

module wave_channel #(
	parameter IS_CHAN_A = 1
) (
	// Clock and reset
	input  wire       clk,
	input  wire       arst_n,
	// Configuration
	input  wire [1:0] action,
	input  wire       mode_high,
	input  wire       mode_fast,
	input  wire       mode_phase,
	// Timer events
	input  wire       match,
	input  wire       force_match,
	input  wire       counting_up,
	input  wire       bottom_evt,
	input  wire       top_evt,
	input  wire       cmp_eq_top,
	// Result
	output wire       connected,
	output wire       wave
);

	reg  wave_r;
	reg  wave_nxt;
	wire pwm;
	wire toggle_ok;
	wire special;
	wire hit;

	////////////////////////////////////////////////////////////////////////
	assign pwm       = mode_fast | mode_phase;
	// Value 1 in PWM: channel B reserved, channel A needs the high mode bit
	assign toggle_ok = ~pwm | (IS_CHAN_A != 0 && mode_high);
	assign connected = (action == `ACT_TOGGLE) ? toggle_ok :
	                   (action != `ACT_OFF);
	// Compare at TOP with upper action bit: match dropped
	assign special   = pwm & action[1] & cmp_eq_top;
	assign hit       = match & ~special;
	assign wave      = wave_r;

	////////////////////////////////////////////////////////////////////////
	always @* begin
		wave_nxt = wave_r;
		if (!pwm) begin
			if (hit | force_match) begin
				case (action)
				`ACT_TOGGLE: wave_nxt = ~wave_r;
				`ACT_CLEAR:  wave_nxt = 1'b0;
				`ACT_SET:    wave_nxt = 1'b1;
				default:     wave_nxt = wave_r;
				endcase
			end
		end else if (action == `ACT_TOGGLE) begin
			if (hit & toggle_ok)
				wave_nxt = ~wave_r;
		end else if (action[1]) begin
			if (mode_fast) begin
				if (bottom_evt)
					wave_nxt = ~action[0];
				else if (hit)
					wave_nxt = action[0];
			end else begin
				// Down-count result held at TOP keeps full duty
				if (special & top_evt)
					wave_nxt = ~action[0];
				else if (hit)
					wave_nxt = counting_up ? action[0] : ~action[0];
			end
		end
	end

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			wave_r <= 1'b0;
		else
			wave_r <= wave_nxt;
	end

endmodule

// ---- design/wave_defines.vh ----
// Register indices, field positions, mode codes and limits for the
// waveform timer. Assumes it is included by bare name, definitions only.
`ifndef WAVE_TIMER_DEFINES_VH
`define WAVE_TIMER_DEFINES_VH

// Register indices; byte address is four times the index
`define IDX_CTRL_A      10'h0b0
`define IDX_CTRL_B      10'h0b1
`define IDX_COUNTER     10'h0b2
`define IDX_COMPARE_A   10'h0b3
`define IDX_COMPARE_B   10'h0b4
`define IDX_IRQ_STATUS  10'h0b8
`define IDX_IRQ_CLEAR   10'h0b9
`define IDX_IRQ_ENABLE  10'h0ba
`define IDX_PIN_DIR     10'h0bb

// Control A fields
`define CA_ACT_A_HI     7
`define CA_ACT_A_LO     6
`define CA_ACT_B_HI     5
`define CA_ACT_B_LO     4
`define CA_MODE_HI      1
`define CA_MODE_LO      0
// Control B fields
`define CB_FORCE_A      7
`define CB_FORCE_B      6
`define CB_MODE_HIGH    3
`define CB_CS_HI        2
`define CB_CS_LO        0
// Interrupt bits
`define IRQ_OVF         0
`define IRQ_MATCH_A     1
`define IRQ_MATCH_B     2

// Mode codes {high, low}
`define MODE_NORMAL     3'h0
`define MODE_PHASE_FF   3'h1
`define MODE_CTC        3'h2
`define MODE_FAST_FF    3'h3
`define MODE_PHASE_OCA  3'h5
`define MODE_FAST_OCA   3'h7

// Action codes
`define ACT_OFF         2'h0
`define ACT_TOGGLE      2'h1
`define ACT_CLEAR       2'h2
`define ACT_SET         2'h3

// Counter limits
`define CNT_MAX         8'hff
`define CNT_BOTTOM      8'h00
`define CNT_ONE         8'h01
`define RESET_BYTE      8'h00
`define CS_STOP         3'h0

`endif

// ---- design/wave_timer.v ----
// Waveform timer: 8-bit counter, two compare channels, Avalon-MM slave.
// Assumes synchronous inputs on SYS_CLK and a word-aligned byte address.
`include "wave_defines.vh"

module wave_timer #(
	parameter ADDR_W = 12
) (
	// Clock and reset
	input  wire              SYS_CLK,
	input  wire              ARST_N,
	// Avalon-MM slave
	input  wire [ADDR_W-1:0] ADDRESS,
	input  wire              READ,
	input  wire              WRITE,
	input  wire [31:0]       WRITEDATA,
	input  wire [3:0]        BYTEENABLE,
	output wire [31:0]       READDATA,
	output wire              WAITREQUEST,
	// Timer tick from prescaler
	input  wire              TICK,
	// Ordinary port data for the two pins
	input  wire              PORT_DATA_A,
	input  wire              PORT_DATA_B,
	// Waveform pins
	output wire              WAVE_OUT_A,
	output wire              WAVE_OUT_A_OE,
	output wire              WAVE_OUT_B,
	output wire              WAVE_OUT_B_OE,
	// Interrupt
	output wire              IRQ
);

	////////////////////////////////////////////////////////////////////////
	// Mode helpers
	function is_fast;
		input [2:0] m;
		is_fast = (m == `MODE_FAST_FF) || (m == `MODE_FAST_OCA);
	endfunction

	function is_phase;
		input [2:0] m;
		is_phase = (m == `MODE_PHASE_FF) || (m == `MODE_PHASE_OCA);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Registers
	reg  [1:0]  act_a_r;
	reg  [1:0]  act_b_r;
	reg  [1:0]  mode_low_r;
	reg         mode_high_r;
	reg  [2:0]  cs_r;
	reg  [7:0]  cnt_r;
	reg  [7:0]  cnt_nxt;
	reg         up_r;
	reg         up_nxt;
	reg         block_r;
	reg  [7:0]  cmp_a_buf_r;
	reg  [7:0]  cmp_b_buf_r;
	reg  [7:0]  cmp_a_r;
	reg  [7:0]  cmp_b_r;
	reg  [2:0]  irq_stat_r;
	reg  [2:0]  irq_en_r;
	reg  [1:0]  pin_dir_r;
	reg         ack_r;
	reg  [7:0]  rdata_r;
	reg  [7:0]  rdata_nxt;
	reg         pin_a_r;
	reg         pin_b_r;

	wire [9:0]  idx;
	wire        wr_en;
	wire        rd_go;
	wire [7:0]  wd;
	wire [2:0]  mode;
	wire        fast;
	wire        phase;
	wire        nonpwm;
	wire [7:0]  top;
	wire        run;
	wire        at_top;
	wire        bottom_evt;
	wire        top_evt;
	wire        cmp_upd;
	wire        ovf_evt;
	wire        match_a;
	wire        match_b;
	wire        force_a;
	wire        force_b;
	wire        conn_a;
	wire        conn_b;
	wire        wave_a;
	wire        wave_b;
	wire [2:0]  irq_evt;
	wire [2:0]  irq_clr;

	////////////////////////////////////////////////////////////////////////
	// Bus slave: one wait cycle, answer on the second edge
	assign idx         = ADDRESS[ADDR_W-1:2];
	assign WAITREQUEST = (READ | WRITE) & ~ack_r;
	assign wr_en       = WRITE & ack_r & BYTEENABLE[0];
	assign rd_go       = READ & ~ack_r;
	assign wd          = WRITEDATA[7:0];
	assign READDATA    = {24'h000000, rdata_r};

	always @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N)
			ack_r <= 1'b0;
		else
			ack_r <= (READ | WRITE) & ~ack_r;
	end

	always @* begin
		rdata_nxt = `RESET_BYTE;
		case (idx)
		`IDX_CTRL_A:
			rdata_nxt = {act_a_r, act_b_r, 2'h0, mode_low_r};
		`IDX_CTRL_B:
			rdata_nxt = {4'h0, mode_high_r, cs_r};
		`IDX_COUNTER:    rdata_nxt = cnt_r;
		`IDX_COMPARE_A:  rdata_nxt = cmp_a_buf_r;
		`IDX_COMPARE_B:  rdata_nxt = cmp_b_buf_r;
		`IDX_IRQ_STATUS: rdata_nxt = {5'h00, irq_stat_r};
		`IDX_IRQ_ENABLE: rdata_nxt = {5'h00, irq_en_r};
		`IDX_PIN_DIR:    rdata_nxt = {6'h00, pin_dir_r};
		default:         rdata_nxt = `RESET_BYTE;
		endcase
	end

	always @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N)
			rdata_r <= `RESET_BYTE;
		else if (rd_go)
			rdata_r <= rdata_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// Control registers
	always @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			act_a_r     <= `ACT_OFF;
			act_b_r     <= `ACT_OFF;
			mode_low_r  <= 2'h0;
			mode_high_r <= 1'b0;
			cs_r        <= `CS_STOP;
			irq_en_r    <= 3'h0;
			pin_dir_r   <= 2'h0;
			cmp_a_buf_r <= `RESET_BYTE;
			cmp_b_buf_r <= `RESET_BYTE;
		end else if (wr_en) begin
			case (idx)
			`IDX_CTRL_A: begin
				act_a_r    <= wd[`CA_ACT_A_HI:`CA_ACT_A_LO];
				act_b_r    <= wd[`CA_ACT_B_HI:`CA_ACT_B_LO];
				mode_low_r <= wd[`CA_MODE_HI:`CA_MODE_LO];
			end
			`IDX_CTRL_B: begin
				mode_high_r <= wd[`CB_MODE_HIGH];
				cs_r        <= wd[`CB_CS_HI:`CB_CS_LO];
			end
			`IDX_COMPARE_A:  cmp_a_buf_r <= wd;
			`IDX_COMPARE_B:  cmp_b_buf_r <= wd;
			`IDX_IRQ_ENABLE: irq_en_r    <= wd[2:0];
			`IDX_PIN_DIR:    pin_dir_r   <= wd[1:0];
			default: begin
			end
			endcase
		end
	end

	// Strobes only, never stored
	assign force_a = wr_en & (idx == `IDX_CTRL_B) & wd[`CB_FORCE_A] & nonpwm;
	assign force_b = wr_en & (idx == `IDX_CTRL_B) & wd[`CB_FORCE_B] & nonpwm;

	////////////////////////////////////////////////////////////////////////
	// Mode decode
	assign mode   = {mode_high_r, mode_low_r};
	assign fast   = is_fast(mode);
	assign phase  = is_phase(mode);
	assign nonpwm = ~fast & ~phase;
	// Reserved modes 4 and 6 count like normal mode
	assign top    = (mode == `MODE_CTC || mode == `MODE_PHASE_OCA ||
	                 mode == `MODE_FAST_OCA) ? cmp_a_r : `CNT_MAX;

	////////////////////////////////////////////////////////////////////////
	// Counter
	assign run        = TICK & (cs_r != `CS_STOP);
	assign at_top     = (cnt_r == top);
	assign bottom_evt = run & fast & at_top;
	assign top_evt    = run & phase & up_r & at_top;

	always @* begin
		cnt_nxt = cnt_r;
		up_nxt  = up_r;
		if (wr_en && idx == `IDX_COUNTER) begin
			cnt_nxt = wd;
		end else if (run) begin
			if (phase) begin
				if (up_r) begin
					if (at_top) begin
						up_nxt  = 1'b0;
						cnt_nxt = (cnt_r == `CNT_BOTTOM) ? cnt_r : cnt_r - `CNT_ONE;
					end else begin
						cnt_nxt = cnt_r + `CNT_ONE;
					end
				end else if (cnt_r == `CNT_BOTTOM) begin
					up_nxt  = 1'b1;
					cnt_nxt = `CNT_ONE;
				end else begin
					cnt_nxt = cnt_r - `CNT_ONE;
				end
			end else begin
				up_nxt  = 1'b1;
				cnt_nxt = at_top ? `CNT_BOTTOM : cnt_r + `CNT_ONE;
			end
		end
	end

	always @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cnt_r   <= `CNT_BOTTOM;
			up_r    <= 1'b1;
			block_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			up_r  <= up_nxt;
			// A counter write suppresses the match on the next tick
			if (wr_en && idx == `IDX_COUNTER)
				block_r <= 1'b1;
			else if (run)
				block_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Compare buffers and events
	assign cmp_upd = nonpwm | bottom_evt | top_evt;

	always @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cmp_a_r <= `RESET_BYTE;
			cmp_b_r <= `RESET_BYTE;
		end else if (cmp_upd) begin
			cmp_a_r <= cmp_a_buf_r;
			cmp_b_r <= cmp_b_buf_r;
		end
	end

	assign match_a = run & ~block_r & (cnt_r == cmp_a_r);
	assign match_b = run & ~block_r & (cnt_r == cmp_b_r);
	assign ovf_evt = run & (phase ? (~up_r & (cnt_r == `CNT_BOTTOM)) :
	                 (mode == `MODE_FAST_OCA) ? at_top : (cnt_r == `CNT_MAX));

	////////////////////////////////////////////////////////////////////////
	// Channels
	wave_channel #(
		.IS_CHAN_A (1)
	) u_chan_a (
		.clk         (SYS_CLK),
		.arst_n      (ARST_N),
		.action      (act_a_r),
		.mode_high   (mode_high_r),
		.mode_fast   (fast),
		.mode_phase  (phase),
		.match       (match_a),
		.force_match (force_a),
		.counting_up (up_r),
		.bottom_evt  (bottom_evt),
		.top_evt     (top_evt),
		.cmp_eq_top  (cmp_a_r == top),
		.connected   (conn_a),
		.wave        (wave_a)
	);

	wave_channel #(
		.IS_CHAN_A (0)
	) u_chan_b (
		.clk         (SYS_CLK),
		.arst_n      (ARST_N),
		.action      (act_b_r),
		.mode_high   (mode_high_r),
		.mode_fast   (fast),
		.mode_phase  (phase),
		.match       (match_b),
		.force_match (force_b),
		.counting_up (up_r),
		.bottom_evt  (bottom_evt),
		.top_evt     (top_evt),
		.cmp_eq_top  (cmp_b_r == top),
		.connected   (conn_b),
		.wave        (wave_b)
	);

	////////////////////////////////////////////////////////////////////////
	// Pins: registered mux, one cycle behind the channel state
	always @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pin_a_r <= 1'b0;
			pin_b_r <= 1'b0;
		end else begin
			pin_a_r <= conn_a ? wave_a : PORT_DATA_A;
			pin_b_r <= conn_b ? wave_b : PORT_DATA_B;
		end
	end

	assign WAVE_OUT_A    = pin_a_r;
	assign WAVE_OUT_A_OE = pin_dir_r[0];
	assign WAVE_OUT_B    = pin_b_r;
	assign WAVE_OUT_B_OE = pin_dir_r[1];

	////////////////////////////////////////////////////////////////////////
	// Interrupt status: set wins over clear; force raises nothing
	assign irq_evt = {match_b, match_a, ovf_evt};
	assign irq_clr = (wr_en && idx == `IDX_IRQ_CLEAR) ? wd[2:0] : 3'h0;

	always @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N)
			irq_stat_r <= 3'h0;
		else
			irq_stat_r <= irq_evt | (irq_stat_r & ~irq_clr);
	end

	assign IRQ = |(irq_stat_r & irq_en_r);

endmodule

// ---- test/pin_load.sv ----
// Load on the two waveform pins.
// Assumes a pull-up on each pin, so an undriven pin reads high.
module pin_load (
	// From the timer
	input wire  wave_a,
	input wire  oe_a,
	input wire  wave_b,
	input wire  oe_b,
	// Pin levels
	output wire pin_a,
	output wire pin_b
);
	// Pull-up wins only while the driver is off
	assign pin_a = oe_a ? wave_a : 1'b1;
	assign pin_b = oe_b ? wave_b : 1'b1;
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for wave_timer against a behavioural model.
// Assumes wave_timer, pin_load and the checker are compiled first.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	////////////////////////////////////////////////////////////////////////
	logic        SYS_CLK = 0;
	logic        ARST_N = 0;
	logic        READ = 0;
	logic        WRITE = 0;
	logic        TICK = 0;
	logic        PORT_DATA_A = 0;
	logic        PORT_DATA_B = 0;
	logic [11:0] ADDRESS = 12'h000;
	logic [31:0] WRITEDATA = 32'h0;
	logic [3:0]  BYTEENABLE = 4'hf;
	wire  [31:0] READDATA;
	wire         WAITREQUEST, WAVE_OUT_A, WAVE_OUT_A_OE, WAVE_OUT_B, WAVE_OUT_B_OE;
	wire         IRQ, pin_a, pin_b;
	int          err_count = 0;
	int          checks_done = 0;
	logic [31:0] seed = 32'hbc2b;
	logic [31:0] r;
	// Model state
	int          m, cnt, up, top, fast, ph, stat;
	int          cmp[2], cmp_nxt[2], act[2], st[2];
	int          modes[6] = '{0, 1, 2, 3, 5, 7};
	logic [1:0]  dirv;
	logic        wa, wb;
	logic [6:0]  ex;
	wire  [6:0]  outs = {WAVE_OUT_A, WAVE_OUT_B, WAVE_OUT_A_OE, WAVE_OUT_B_OE, IRQ, pin_a, pin_b};

	always #5 SYS_CLK = ~SYS_CLK;

	wave_timer #(.ADDR_W(12)) dut (
		.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
		.WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
		.WAITREQUEST(WAITREQUEST), .TICK(TICK), .PORT_DATA_A(PORT_DATA_A),
		.PORT_DATA_B(PORT_DATA_B), .WAVE_OUT_A(WAVE_OUT_A), .WAVE_OUT_A_OE(WAVE_OUT_A_OE),
		.WAVE_OUT_B(WAVE_OUT_B), .WAVE_OUT_B_OE(WAVE_OUT_B_OE), .IRQ(IRQ)
	);
	pin_load load (
		.wave_a(WAVE_OUT_A), .oe_a(WAVE_OUT_A_OE), .wave_b(WAVE_OUT_B),
		.oe_b(WAVE_OUT_B_OE), .pin_a(pin_a), .pin_b(pin_b)
	);
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [9:0] i, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge SYS_CLK);
		ADDRESS <= {i, 2'b00};
		WRITEDATA <= {24'h0, d};
		READ <= !wr;
		WRITE <= wr;
		do begin
			@(posedge SYS_CLK);
		end while (WAITREQUEST !== 1'b0);
		q = READDATA;
		READ <= 1'b0;
		WRITE <= 1'b0;
	endtask

	task automatic wr(input logic [9:0] i, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, i, d, q);
	endtask

	task automatic rd(input logic [9:0] i, input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, i, 8'h00, q);
		chk(q, {24'h0, e});
	endtask

	task automatic rst();
		@(posedge SYS_CLK);
		r = rnd();
		ARST_N <= 1'b0;
		PORT_DATA_A <= r[0];
		PORT_DATA_B <= r[1];
		repeat (8) @(posedge SYS_CLK);
		ARST_N <= 1'b1;
	endtask
	////////////////////////////////////////////////////////////////////////
	function automatic logic conn(int c);
		return act[c] != 0 && !((fast || ph) && act[c] == 1 && (c == 1 || m < 4));
	endfunction

	// Phase PWM picks its level from the count direction
	function automatic void hit(int c, int d);
		if (act[c] == 1) st[c] ^= 1;
		else if (act[c] > 1) st[c] = (act[c] == 3) ^ (ph && !d);
	endfunction

	task automatic tk();
		@(posedge SYS_CLK);
		TICK <= 1'b1;
		@(posedge SYS_CLK);
		TICK <= 1'b0;
		top = (m == 2 || m >= 5) ? cmp[0] : 255;
		for (int c = 0; c < 2; c++) begin
			if (cnt == cmp[c]) begin
				stat |= 2 << c;
				if (!(fast && cmp[c] == top && act[c] > 1)) hit(c, cnt == top ? 0 : up);
			end
			if (fast && cnt == top && act[c] > 1) st[c] = (act[c] == 2);
		end
		if ((m == 7 ? cnt == top : !ph && cnt == 255) || (ph && cnt == 0 && !up)) stat |= 1;
		// PWM compares load from the buffer only at the turn of the count
		if ((fast || (ph && up)) && cnt == top) cmp = cmp_nxt;
		if (ph && (cnt == top || cnt == 0)) up = (cnt == 0);
		cnt = ph ? cnt + (up ? 1 : -1) : (cnt == top ? 0 : (cnt + 1) & 255);
		repeat (2) @(posedge SYS_CLK);
		@(negedge SYS_CLK);
		wa = conn(0) ? st[0][0] : PORT_DATA_A;
		wb = conn(1) ? st[1][0] : PORT_DATA_B;
		ex = {wa, wb, dirv[0], dirv[1], stat != 0, dirv[0] ? wa : 1'b1, dirv[1] ? wb : 1'b1};
		chk(outs[6:5], ex[6:5]);
		chk(outs[4:0], ex[4:0]);
	endtask

	// Compares are loaded in normal mode so PWM starts with them active
	task automatic run(int mode, int a);
		logic [2:0] mb;
		rst();
		m = mode;
		mb = 3'(mode);
		fast = (m == 3 || m == 7);
		ph = (m == 1 || m == 5);
		act[0] = a;
		act[1] = 3 - a;
		cnt = 0;
		up = 1;
		stat = 0;
		st[0] = 0;
		st[1] = 0;
		r = rnd();
		dirv = r[1:0];
		cmp[0] = 8 + r[15:8] % 240;
		cmp[1] = 8 + r[23:16] % 240;
		cmp_nxt = cmp;
		wr(10'h0bb, {6'h0, dirv});
		wr(10'h0ba, 8'h07);
		wr(10'h0b3, 8'(cmp[0]));
		wr(10'h0b4, 8'(cmp[1]));
		wr(10'h0b0, {2'(a), 2'(3 - a), 2'b00, mb[1:0]});
		wr(10'h0b1, {(fast || ph) ? 2'b00 : 2'b11, 2'b00, mb[2], 3'h1});
		if (!(fast || ph)) begin
			hit(0, 1);
			hit(1, 1);
		end
		rd(10'h0b0, {2'(a), 2'(3 - a), 2'b00, mb[1:0]});
		rd(10'h0b1, {4'h0, mb[2], 3'h1});
		repeat (260) tk();
		r = rnd();
		cmp_nxt[0] = 8 + r[15:8] % 240;
		cmp_nxt[1] = 8 + r[23:16] % 240;
		wr(10'h0b3, 8'(cmp_nxt[0]));
		wr(10'h0b4, 8'(cmp_nxt[1]));
		rd(10'h0b3, 8'(cmp_nxt[0]));
		if (!(fast || ph)) cmp = cmp_nxt;
		repeat (260) tk();
		rd(10'h0b8, 8'(stat));
		wr(10'h0ba, 8'h00);
		@(negedge SYS_CLK);
		chk(IRQ, 1'b0);
		wr(10'h0b9, 8'h07);
		rd(10'h0b8, 8'h00);
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		rst();
		rd(10'h0b0, 8'h00);
		rd(10'h0b1, 8'h00);
		wr(10'h0c0, 8'hff);
		rd(10'h0c0, 8'h00);
		foreach (modes[k]) begin
			for (int a = 0; a < 4; a++) begin
				run(modes[k], a);
			end
		end
		test_done();
	end

	// About twice the expected run length
	initial begin
		#1000000;
		err_count++;
		test_done();
	end
endmodule

// ---- test/wave_timer_asserts.sv ----
// Port checker for the waveform timer.
// Assumes a bind to wave_timer, one clock, async active-low reset.
module wave_timer_asserts #(
	parameter ADDR_W = 12
) (
	// Clock and reset
	input wire              SYS_CLK,
	input wire              ARST_N,
	// Bus
	input wire [ADDR_W-1:0] ADDRESS,
	input wire              READ,
	input wire              WRITE,
	input wire [31:0]       WRITEDATA,
	input wire [3:0]        BYTEENABLE,
	input wire [31:0]       READDATA,
	input wire              WAITREQUEST,
	// Timer and pins
	input wire              TICK,
	input wire              PORT_DATA_A,
	input wire              PORT_DATA_B,
	input wire              WAVE_OUT_A,
	input wire              WAVE_OUT_A_OE,
	input wire              WAVE_OUT_B,
	input wire              WAVE_OUT_B_OE,
	input wire              IRQ
);
	wire [ADDR_W-3:0] idx = ADDRESS[ADDR_W-1:2];
	default clocking @(posedge SYS_CLK);
	endclocking
	default disable iff (!ARST_N);
	////////////////////////////////////////////////////////////////////////
	sequence req_start;
		(READ || WRITE) && !$past(READ || WRITE);
	endsequence
	sequence rd_at(i);
		READ && !WAITREQUEST && idx == i;
	endsequence
	sequence wr_at(i, d);
		WRITE && !WAITREQUEST && BYTEENABLE[0] && idx == i && WRITEDATA[2:0] == d;
	endsequence
	////////////////////////////////////////////////////////////////////////
	AST_ONE_WAIT:
		assert property (req_start |-> WAITREQUEST ##1 !WAITREQUEST)
		else $error("wait state count wrong");
	AST_RSVD_ZERO:
		assert property (rd_at(10'h0b0) |-> READDATA[3:2] == 2'h0)
		else $error("reserved control bits not zero");
	AST_FORCE_ZERO:
		assert property (rd_at(10'h0b1) |-> READDATA[7:4] == 4'h0)
		else $error("force strobe read back nonzero");
	AST_IRQ_CLEAR:
		assert property (wr_at(10'h0b9, 3'h7) ##0 !TICK |=> !IRQ)
		else $error("interrupt stays after clear");
	AST_IRQ_MASK:
		assert property (wr_at(10'h0ba, 3'h0) |=> !IRQ)
		else $error("interrupt stays when masked");
	AST_IRQ_CAUSE:
		assert property ($rose(IRQ) |-> $past(TICK) || ($past(WRITE) && $past(idx) != 10'h0b1))
		else $error("interrupt rose without cause");
	AST_OE_A:
		assert property ($changed(WAVE_OUT_A_OE) |-> $past(WRITE))
		else $error("pin enable moved without write");
	// Force writes reach the pin two edges late, port data one edge late
	AST_WAVE_A:
		assert property ($changed(WAVE_OUT_A) |-> $past(TICK, 2) || $past(WRITE)
			|| $past(WRITE, 2) || !$past(ARST_N, 3)
			|| $past(PORT_DATA_A) != $past(PORT_DATA_A, 2))
		else $error("wave output moved without cause");
endmodule

bind wave_timer wave_timer_asserts #(.ADDR_W(ADDR_W)) chk (
	.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
	.WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
	.WAITREQUEST(WAITREQUEST), .TICK(TICK), .PORT_DATA_A(PORT_DATA_A),
	.PORT_DATA_B(PORT_DATA_B), .WAVE_OUT_A(WAVE_OUT_A), .WAVE_OUT_A_OE(WAVE_OUT_A_OE),
	.WAVE_OUT_B(WAVE_OUT_B), .WAVE_OUT_B_OE(WAVE_OUT_B_OE), .IRQ(IRQ)
);
